// >>> verilog/pfsel_defines.vh
`ifndef PFSEL_DEFINES_VH
`define PFSEL_DEFINES_VH

// register byte offsets on the bus
`define PFSEL_ADDR_W          8
`define PFSEL_OFF_FUNC        8'h00
`define PFSEL_OFF_PADS        8'h04

// pin function select register layout
`define PFSEL_FUNC_W          19
`define PFSEL_FUNC_RESET      19'h6703d
`define PFSEL_BIT_CLK_SRC     16
`define PFSEL_BIT_EXT_CLK1    10
`define PFSEL_BIT_EXT_CLK0    9
`define PFSEL_BIT_INFRARED    8
`define PFSEL_BIT_UART3_MODEM 7
`define PFSEL_BIT_AUDIO_DIN   6
`define PFSEL_BIT_AUDIO       5
`define PFSEL_BIT_ETH0        4
`define PFSEL_BIT_UART0_TX    3

// shared pad indices
`define PFSEL_PADS            20
`define PFSEL_PAD_GPIO3       0
`define PFSEL_PAD_GPIO2       1
`define PFSEL_PAD_GPIO15      2
`define PFSEL_PAD_UR3_LO      3
`define PFSEL_PAD_UR3_HI      8
`define PFSEL_PAD_GPIO8       9
`define PFSEL_PAD_AUD_LO      10
`define PFSEL_PAD_AUD_HI      12
`define PFSEL_PAD_ETH_LO      13
`define PFSEL_PAD_ETH_HI      18
`define PFSEL_PAD_GPIO212     19

// idle level seen by a peripheral input whose pad is not its own
`define PFSEL_PER_IDLE        20'h001f8

// bus responses
`define PFSEL_RESP_OKAY       2'h0
`define PFSEL_RESP_SLVERR     2'h2

`endif

// >>> verilog/pfsel_axil.v
`timescale 1ns/1ps
`include "pfsel_defines.vh"

module pfsel_axil (
	// clock and reset
	input  wire                      core_clk_i,
	input  wire                      rst_b_i,
	// axi4-lite slave
	input  wire [`PFSEL_ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire                      s_axi_awvalid_i,
	output wire                      s_axi_awready_o,
	input  wire [31:0]               s_axi_wdata_i,
	input  wire [3:0]                s_axi_wstrb_i,
	input  wire                      s_axi_wvalid_i,
	output wire                      s_axi_wready_o,
	output reg  [1:0]                s_axi_bresp_o,
	output reg                       s_axi_bvalid_o,
	input  wire                      s_axi_bready_i,
	input  wire [`PFSEL_ADDR_W-1:0]  s_axi_araddr_i,
	input  wire                      s_axi_arvalid_i,
	output wire                      s_axi_arready_o,
	output reg  [31:0]               s_axi_rdata_o,
	output reg  [1:0]                s_axi_rresp_o,
	output reg                       s_axi_rvalid_o,
	input  wire                      s_axi_rready_i,
	// register file side
	output wire                      wr_en_o,
	output wire [`PFSEL_ADDR_W-1:0]  wr_addr_o,
	output wire [31:0]               wr_data_o,
	output wire [3:0]                wr_strb_o,
	input  wire                      wr_ok_i,
	output wire [`PFSEL_ADDR_W-1:0]  rd_addr_o,
	input  wire [31:0]               rd_data_i,
	input  wire                      rd_ok_i
);

	reg                     aw_q;
	reg                     w_q;
	reg [`PFSEL_ADDR_W-1:0] awaddr_q;
	reg [31:0]              wdata_q;
	reg [3:0]               wstrb_q;

	// each channel is taken once and held until the response leaves
	assign s_axi_awready_o = !aw_q && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_q && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_en_o         = aw_q && w_q && !s_axi_bvalid_o;
	assign wr_addr_o       = awaddr_q;
	assign wr_data_o       = wdata_q;
	assign wr_strb_o       = wstrb_q;
	assign rd_addr_o       = s_axi_araddr_i;

	// write path: address and data in either order, response after both
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_q           <= 1'b0;
			w_q            <= 1'b0;
			awaddr_q       <= {`PFSEL_ADDR_W{1'b0}};
			wdata_q        <= 32'h0;
			wstrb_q        <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `PFSEL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (wr_en_o) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok_i ? `PFSEL_RESP_OKAY
				                          : `PFSEL_RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_q           <= 1'b0;
				w_q            <= 1'b0;
			end
		end
	end

	// read path: data captured on the address edge, answer next cycle
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h0;
			s_axi_rresp_o  <= `PFSEL_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_ok_i ? rd_data_i : 32'h0;
			s_axi_rresp_o  <= rd_ok_i ? `PFSEL_RESP_OKAY
			                          : `PFSEL_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule // pfsel_axil

// >>> verilog/pfsel_pad_mux.v
`timescale 1ns/1ps
`include "pfsel_defines.vh"

module pfsel_pad_mux #(
	parameter          W    = 20,
	parameter [W-1:0]  IDLE = {W{1'b0}}
) (
	// clock and reset
	input  wire          core_clk_i,
	input  wire          rst_b_i,
	// owner per pad, 1 = peripheral
	input  wire [W-1:0]  sel_i,
	// general-purpose side
	input  wire [W-1:0]  gpio_out_i,
	input  wire [W-1:0]  gpio_oe_n_i,
	output reg  [W-1:0]  gpio_in_o,
	// peripheral side
	input  wire [W-1:0]  per_out_i,
	input  wire [W-1:0]  per_oe_n_i,
	output reg  [W-1:0]  per_in_o,
	// pad side, input already synchronised
	input  wire [W-1:0]  pad_sync_i,
	output wire [W-1:0]  pad_out_o,
	output wire [W-1:0]  pad_oe_n_o
);

	// exactly one owner drives each pad
	assign pad_out_o  = (sel_i & per_out_i) | (~sel_i & gpio_out_i);
	assign pad_oe_n_o = (sel_i & per_oe_n_i) | (~sel_i & gpio_oe_n_i);

	// the losing side sees a quiet level, so no false edges reach it
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gpio_in_o <= {W{1'b0}};
			per_in_o  <= IDLE;
		end else begin
			gpio_in_o <= ~sel_i & pad_sync_i;
			per_in_o  <= (sel_i & pad_sync_i) | (~sel_i & IDLE);
		end
	end

endmodule // pfsel_pad_mux

// >>> verilog/pfsel_top.v
`timescale 1ns/1ps
`include "pfsel_defines.vh"

// How it works
// - bit 10 gives gpio3 pad to clock1
// - bit 9 gives gpio2 pad to clock
// - bit 16 picks clock source when bit9
// - bit16 zero clock0, one 32 kHz
// - bit 8 gives gpio15 to infrared select
// - bit 7 gives six pads to uart3 modem
// - bit 6 gives gpio8 to audio input
// - bit 5 zero gives three pads audio
// - bit 4 zero gives pads ethernet0
// - bit 3 zero gives pad uart0 transmit
// - never gpio and peripheral together
module pfsel_top (
	// clock and reset
	input  wire                      core_clk_i,
	input  wire                      rst_b_i,
	// axi4-lite slave
	input  wire [`PFSEL_ADDR_W-1:0]  s_axi_awaddr_i,
	input  wire                      s_axi_awvalid_i,
	output wire                      s_axi_awready_o,
	input  wire [31:0]               s_axi_wdata_i,
	input  wire [3:0]                s_axi_wstrb_i,
	input  wire                      s_axi_wvalid_i,
	output wire                      s_axi_wready_o,
	output wire [1:0]                s_axi_bresp_o,
	output wire                      s_axi_bvalid_o,
	input  wire                      s_axi_bready_i,
	input  wire [`PFSEL_ADDR_W-1:0]  s_axi_araddr_i,
	input  wire                      s_axi_arvalid_i,
	output wire                      s_axi_arready_o,
	output wire [31:0]               s_axi_rdata_o,
	output wire [1:0]                s_axi_rresp_o,
	output wire                      s_axi_rvalid_o,
	input  wire                      s_axi_rready_i,
	// whole select register, for the other pin owners
	output wire [`PFSEL_FUNC_W-1:0]  pin_function_o,
	// general-purpose pin logic, one bit per shared pad
	input  wire [`PFSEL_PADS-1:0]    gpio_out_i,
	input  wire [`PFSEL_PADS-1:0]    gpio_oe_n_i,
	output wire [`PFSEL_PADS-1:0]    gpio_in_o,
	// clock and infrared sources
	input  wire                      external_clock_out_1_i,
	input  wire                      external_clock_out_0_i,
	input  wire                      osc_32k_clock_i,
	input  wire                      infrared_mode_select_out_i,
	// uart3 modem control
	input  wire                      uart3_terminal_ready_n_i,
	input  wire                      uart3_request_to_send_n_i,
	output wire                      uart3_ring_indicator_n_o,
	output wire                      uart3_carrier_detect_n_o,
	output wire                      uart3_set_ready_n_o,
	output wire                      uart3_clear_to_send_n_o,
	// serial audio
	output wire                      serial_audio_data_in_o,
	input  wire                      serial_audio_word_select_i,
	input  wire                      serial_audio_word_select_oe_n_i,
	output wire                      serial_audio_word_select_o,
	input  wire                      serial_audio_bit_clock_i,
	input  wire                      serial_audio_bit_clock_oe_n_i,
	output wire                      serial_audio_bit_clock_o,
	input  wire                      serial_audio_data_bidir_i,
	input  wire                      serial_audio_data_bidir_oe_n_i,
	output wire                      serial_audio_data_bidir_o,
	// ethernet port 0 transmit and management
	input  wire [3:0]                eth0_tx_data_i,
	input  wire                      eth0_tx_enable_i,
	input  wire                      eth0_mgmt_clock_i,
	// uart0 transmit
	input  wire                      uart0_tx_data_i,
	// shared pads
	input  wire [`PFSEL_PADS-1:0]    pad_in_i,
	output wire [`PFSEL_PADS-1:0]    pad_out_o,
	output wire [`PFSEL_PADS-1:0]    pad_oe_n_o
);

	// address match on a whole aligned word
	function hit;
		input [`PFSEL_ADDR_W-1:0] addr;
		input [`PFSEL_ADDR_W-1:0] off;
		begin
			hit = (addr[`PFSEL_ADDR_W-1:2] == off[`PFSEL_ADDR_W-1:2]);
		end
	endfunction

	// byte-lane merge of a write into the select register
	function [`PFSEL_FUNC_W-1:0] merge;
		input [`PFSEL_FUNC_W-1:0] old;
		input [31:0]              data;
		input [3:0]               strb;
		reg   [31:0]              tmp;
		integer                   i;
		begin
			tmp = {13'h0, old};
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					tmp[i*8 +: 8] = data[i*8 +: 8];
				end
			end
			merge = tmp[`PFSEL_FUNC_W-1:0];
		end
	endfunction

	wire                     wr_en;
	wire [`PFSEL_ADDR_W-1:0] wr_addr;
	wire [31:0]              wr_data;
	wire [3:0]               wr_strb;
	wire [`PFSEL_ADDR_W-1:0] rd_addr;
	reg  [31:0]              rd_data;
	wire                     wr_ok;
	wire                     rd_ok;

	reg  [`PFSEL_FUNC_W-1:0] func_q;
	wire [`PFSEL_FUNC_W-1:0] func_d;
	reg  [`PFSEL_PADS-1:0]   pad_meta_q;
	reg  [`PFSEL_PADS-1:0]   pad_sync_q;

	wire [`PFSEL_PADS-1:0]   sel;
	wire [`PFSEL_PADS-1:0]   per_out;
	wire [`PFSEL_PADS-1:0]   per_oe_n;
	wire [`PFSEL_PADS-1:0]   per_in;

	wire                     ext_clk1_sel;
	wire                     ext_clk0_sel;
	wire                     clk_src_sel;
	wire                     infrared_sel;
	wire                     uart3_modem_sel;
	wire                     audio_din_sel;
	wire                     audio_gpio_sel;
	wire                     eth0_gpio_sel;
	wire                     uart0_gpio_sel;
	wire                     clock0_pad_value;

	// bus slave
	pfsel_axil u_axil (
		.core_clk_i      (core_clk_i),
		.rst_b_i         (rst_b_i),
		.s_axi_awaddr_i  (s_axi_awaddr_i),
		.s_axi_awvalid_i (s_axi_awvalid_i),
		.s_axi_awready_o (s_axi_awready_o),
		.s_axi_wdata_i   (s_axi_wdata_i),
		.s_axi_wstrb_i   (s_axi_wstrb_i),
		.s_axi_wvalid_i  (s_axi_wvalid_i),
		.s_axi_wready_o  (s_axi_wready_o),
		.s_axi_bresp_o   (s_axi_bresp_o),
		.s_axi_bvalid_o  (s_axi_bvalid_o),
		.s_axi_bready_i  (s_axi_bready_i),
		.s_axi_araddr_i  (s_axi_araddr_i),
		.s_axi_arvalid_i (s_axi_arvalid_i),
		.s_axi_arready_o (s_axi_arready_o),
		.s_axi_rdata_o   (s_axi_rdata_o),
		.s_axi_rresp_o   (s_axi_rresp_o),
		.s_axi_rvalid_o  (s_axi_rvalid_o),
		.s_axi_rready_i  (s_axi_rready_i),
		.wr_en_o         (wr_en),
		.wr_addr_o       (wr_addr),
		.wr_data_o       (wr_data),
		.wr_strb_o       (wr_strb),
		.wr_ok_i         (wr_ok),
		.rd_addr_o       (rd_addr),
		.rd_data_i       (rd_data),
		.rd_ok_i         (rd_ok)
	);

	// pad state register is read-only, so a write there is refused
	assign wr_ok = hit(wr_addr, `PFSEL_OFF_FUNC);
	assign rd_ok = hit(rd_addr, `PFSEL_OFF_FUNC) ||
	               hit(rd_addr, `PFSEL_OFF_PADS);

	// reserved bits above the select fields read as zero
	always @* begin
		if (hit(rd_addr, `PFSEL_OFF_FUNC)) begin
			rd_data = {13'h0, func_q};
		end else if (hit(rd_addr, `PFSEL_OFF_PADS)) begin
			rd_data = {12'h0, pad_sync_q};
		end else begin
			rd_data = 32'h0;
		end
	end

	// select register; every field keeps its own reset default
	assign func_d = (wr_en && wr_ok) ? merge(func_q, wr_data, wr_strb)
	                                 : func_q;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			func_q <= `PFSEL_FUNC_RESET;
		end else begin
			func_q <= func_d;
		end
	end

	assign pin_function_o = func_q;

	// pads are asynchronous to the core clock
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pad_meta_q <= {`PFSEL_PADS{1'b0}};
			pad_sync_q <= {`PFSEL_PADS{1'b0}};
		end else begin
			pad_meta_q <= pad_in_i;
			pad_sync_q <= pad_meta_q;
		end
	end

	// field decode
	assign ext_clk1_sel    = func_q[`PFSEL_BIT_EXT_CLK1];
	assign ext_clk0_sel    = func_q[`PFSEL_BIT_EXT_CLK0];
	assign clk_src_sel     = func_q[`PFSEL_BIT_CLK_SRC];
	assign infrared_sel    = func_q[`PFSEL_BIT_INFRARED];
	assign uart3_modem_sel = func_q[`PFSEL_BIT_UART3_MODEM];
	assign audio_din_sel   = func_q[`PFSEL_BIT_AUDIO_DIN];
	assign audio_gpio_sel  = func_q[`PFSEL_BIT_AUDIO];
	assign eth0_gpio_sel   = func_q[`PFSEL_BIT_ETH0];
	assign uart0_gpio_sel  = func_q[`PFSEL_BIT_UART0_TX];

	// clock source bit only matters while bit 9 owns the pad
	assign clock0_pad_value = clk_src_sel ? osc_32k_clock_i
	                                      : external_clock_out_0_i;

	// owner per pad, 1 = peripheral; some fields are active low
	assign sel[`PFSEL_PAD_GPIO3]   = ext_clk1_sel;
	assign sel[`PFSEL_PAD_GPIO2]   = ext_clk0_sel;
	assign sel[`PFSEL_PAD_GPIO15]  = infrared_sel;
	assign sel[`PFSEL_PAD_UR3_HI:`PFSEL_PAD_UR3_LO] =
		{6{uart3_modem_sel}};
	assign sel[`PFSEL_PAD_GPIO8]   = audio_din_sel;
	assign sel[`PFSEL_PAD_AUD_HI:`PFSEL_PAD_AUD_LO] =
		{3{~audio_gpio_sel}};
	assign sel[`PFSEL_PAD_ETH_HI:`PFSEL_PAD_ETH_LO] =
		{6{~eth0_gpio_sel}};
	assign sel[`PFSEL_PAD_GPIO212] = ~uart0_gpio_sel;

	// peripheral pad values; clock outputs pass straight through,
	// a flop here would halve and skew them
	assign per_out = {
		uart0_tx_data_i,                        // gpio212
		eth0_mgmt_clock_i,                      // gpio215
		eth0_tx_enable_i,                       // gpio28
		eth0_tx_data_i,                         // gpio27..24
		serial_audio_data_bidir_i,              // gpio31
		serial_audio_bit_clock_i,               // gpio30
		serial_audio_word_select_i,             // gpio29
		1'b0,                                   // gpio8, input only
		4'h0,                                   // gpio14..11, inputs
		uart3_request_to_send_n_i,              // gpio10
		uart3_terminal_ready_n_i,               // gpio9
		infrared_mode_select_out_i,             // gpio15
		clock0_pad_value,                       // gpio2
		external_clock_out_1_i                  // gpio3
	};

	// peripheral enables, active low; modem status lines only listen
	assign per_oe_n = {
		1'b0,                                   // gpio212
		6'h00,                                  // ethernet pads
		serial_audio_data_bidir_oe_n_i,
		serial_audio_bit_clock_oe_n_i,
		serial_audio_word_select_oe_n_i,
		1'b1,                                   // gpio8
		4'hf,                                   // modem status pads
		2'h0,                                   // modem control pads
		3'h0                                    // clocks, infrared
	};

	// pad ownership switch
	pfsel_pad_mux #(
		.W    (`PFSEL_PADS),
		.IDLE (`PFSEL_PER_IDLE)
	) u_pad_mux (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.sel_i       (sel),
		.gpio_out_i  (gpio_out_i),
		.gpio_oe_n_i (gpio_oe_n_i),
		.gpio_in_o   (gpio_in_o),
		.per_out_i   (per_out),
		.per_oe_n_i  (per_oe_n),
		.per_in_o    (per_in),
		.pad_sync_i  (pad_sync_q),
		.pad_out_o   (pad_out_o),
		.pad_oe_n_o  (pad_oe_n_o)
	);

	// peripheral inputs; modem lines idle high when unrouted, which
	// only masks edges, software must still gate the uart3 irq
	assign uart3_ring_indicator_n_o   = per_in[5];
	assign uart3_carrier_detect_n_o   = per_in[6];
	assign uart3_set_ready_n_o        = per_in[7];
	assign uart3_clear_to_send_n_o    = per_in[8];
	assign serial_audio_data_in_o     = per_in[`PFSEL_PAD_GPIO8];
	assign serial_audio_word_select_o = per_in[10];
	assign serial_audio_bit_clock_o   = per_in[11];
	assign serial_audio_data_bidir_o  = per_in[12];

endmodule // pfsel_top

// >>> testbench/pfsel_far_side.sv
`timescale 1ns/1ps
// board and clock sources beyond the pads
module pfsel_far_side (
	// clock and reset
	input  wire         core_clk_i,
	input  wire         rst_b_i,
	// pad side of the mux
	input  wire [19:0]  pad_out_i,
	input  wire [19:0]  pad_oe_n_i,
	input  wire [19:0]  board_i,
	output wire [19:0]  pad_in_o,
	// clock sources
	output wire         clk1_o,
	output wire         clk0_o,
	output wire         osc_o
);
	reg [3:0] div_q;
	// free running dividers, three unequal rates
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			div_q <= 4'h0;
		else
			div_q <= div_q + 4'h1;
	end
	assign clk1_o = div_q[0];
	assign clk0_o = div_q[1];
	assign osc_o = div_q[3];
	// a driven pad wins, a released pad shows the board level
	assign pad_in_o = (pad_out_i & ~pad_oe_n_i) | (board_i & pad_oe_n_i);
endmodule // pfsel_far_side

// >>> testbench/pfsel_chk.sv
`timescale 1ns/1ps
`include "pfsel_defines.vh"
// pad ownership relations at the top ports
module pfsel_chk (
	// clock and reset
	input  wire                      core_clk_i,
	input  wire                      rst_b_i,
	// select and sources
	input  wire [`PFSEL_FUNC_W-1:0]  pin_function_o,
	input  wire [`PFSEL_PADS-1:0]    gpio_out_i,
	input  wire [`PFSEL_PADS-1:0]    gpio_oe_n_i,
	input  wire [`PFSEL_PADS-1:0]    gpio_in_o,
	input  wire                      external_clock_out_1_i,
	input  wire                      external_clock_out_0_i,
	input  wire                      osc_32k_clock_i,
	input  wire                      infrared_mode_select_out_i,
	input  wire                      uart3_terminal_ready_n_i,
	input  wire                      serial_audio_word_select_oe_n_i,
	input  wire [3:0]                eth0_tx_data_i,
	input  wire                      uart0_tx_data_i,
	// pads
	input  wire [`PFSEL_PADS-1:0]    pad_out_o,
	input  wire [`PFSEL_PADS-1:0]    pad_oe_n_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	AST_CLK1_PAD: assert property (pin_function_o[10] |->
		pad_out_o[0] == external_clock_out_1_i && !pad_oe_n_o[0])
		else $error("clock 1 pad wrong");
	AST_GPIO3_PAD: assert property (!pin_function_o[10] |->
		{pad_out_o[0], pad_oe_n_o[0]} == {gpio_out_i[0], gpio_oe_n_i[0]})
		else $error("gpio 3 pad wrong");
	AST_CLK0_PAD: assert property (pin_function_o[9] |-> !pad_oe_n_o[1] &&
		pad_out_o[1] == (pin_function_o[16] ? osc_32k_clock_i :
		external_clock_out_0_i)) else $error("clock 0 pad wrong");
	AST_IR_PAD: assert property (pin_function_o[8] |->
		pad_out_o[2] == infrared_mode_select_out_i && !pad_oe_n_o[2])
		else $error("infrared pad wrong");
	AST_MODEM_PADS: assert property (pin_function_o[7] |->
		pad_oe_n_o[8:3] == 6'h3c && pad_out_o[3] == uart3_terminal_ready_n_i)
		else $error("modem pads wrong");
	AST_AUDIO_PAD: assert property (!pin_function_o[5] |->
		pad_oe_n_o[10] == serial_audio_word_select_oe_n_i)
		else $error("audio pad enable wrong");
	AST_ETH_PADS: assert property (!pin_function_o[4] |->
		pad_out_o[16:13] == eth0_tx_data_i && pad_oe_n_o[18:13] == 6'h00)
		else $error("ethernet pads wrong");
	AST_UART0_PAD: assert property (!pin_function_o[3] |->
		pad_out_o[19] == uart0_tx_data_i && !pad_oe_n_o[19])
		else $error("uart0 pad wrong");
	AST_GPIO_ISOLATE: assert property (!pin_function_o[4] [*3] |->
		gpio_in_o[18:13] == 6'h00) else $error("gpio sees owned pads");
endmodule // pfsel_chk
bind pfsel_top pfsel_chk i_pfsel_chk (.*);

// >>> testbench/tb_pin_function_select_low_fields.sv
`timescale 1ns/1ps
`include "pfsel_defines.vh"
module tb_pin_function_select_low_fields;
	// clock, reset, bus
	reg         core_clk_i = 1'b0, rst_b_i = 1'b0;
	reg  [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	reg  [31:0] s_axi_wdata_i = 32'h0;
	reg  [3:0]  s_axi_wstrb_i = 4'h0;
	reg         s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	reg         s_axi_arvalid_i = 1'b0;
	reg         s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
	wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire        s_axi_arready_o, s_axi_rvalid_o;
	wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	// pin side
	wire [18:0] pin_function_o;
	reg  [19:0] gpio_out_i = 20'h0, gpio_oe_n_i = 20'hfffff;
	reg  [19:0] board = 20'ha5a5a;
	wire [19:0] gpio_in_o, pad_in_i, pad_out_o, pad_oe_n_o;
	wire        external_clock_out_1_i, external_clock_out_0_i;
	wire        osc_32k_clock_i;
	reg         infrared_mode_select_out_i = 1'b0;
	reg         uart3_terminal_ready_n_i = 1'b1;
	reg         uart3_request_to_send_n_i = 1'b1;
	wire        uart3_ring_indicator_n_o, uart3_carrier_detect_n_o;
	wire        uart3_set_ready_n_o, uart3_clear_to_send_n_o;
	wire        serial_audio_data_in_o, serial_audio_word_select_o;
	wire        serial_audio_bit_clock_o, serial_audio_data_bidir_o;
	reg         serial_audio_word_select_i = 1'b0;
	reg         serial_audio_bit_clock_i = 1'b0;
	reg         serial_audio_data_bidir_i = 1'b0;
	reg         serial_audio_word_select_oe_n_i = 1'b1;
	reg         serial_audio_bit_clock_oe_n_i = 1'b1;
	reg         serial_audio_data_bidir_oe_n_i = 1'b1;
	reg  [3:0]  eth0_tx_data_i = 4'h0;
	reg         eth0_tx_enable_i = 1'b0, eth0_mgmt_clock_i = 1'b0;
	reg         uart0_tx_data_i = 1'b1;
	// bench state
	integer     n_mismatch = 0, num_checks = 0, cyc = 0, k;
	reg  [18:0] sel_exp;
	reg  [31:0] rd, v;
	reg  [1:0]  rs;

	pfsel_top i_pfsel_top (.*);
	pfsel_far_side i_pfsel_far_side (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.pad_out_i  (pad_out_o),
		.pad_oe_n_i (pad_oe_n_o),
		.board_i    (board),
		.pad_in_o   (pad_in_i),
		.clk1_o     (external_clock_out_1_i),
		.clk0_o     (external_clock_out_0_i),
		.osc_o      (osc_32k_clock_i)
	);

	always #50 core_clk_i = ~core_clk_i;
	// hang guard, the run needs well under a thousand cycles
	always @(posedge core_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			print_verdict;
		end
	end

	task print_verdict;
		begin
			if (n_mismatch == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task cmp_word(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: %h not %h", $time, got, exp);
			end
		end
	endtask
	task cmp_pads(input [19:0] got, input [19:0] exp, input [19:0] m);
		begin
			num_checks = num_checks + 1;
			if ((got & m) !== (exp & m)) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: %h not %h", $time, got, exp);
			end
		end
	endtask
	// ready is read mid-cycle, so it is the value the next edge samples
	task axi_write(input [7:0] a, input [31:0] d, input [3:0] s,
		output [1:0] r);
		reg aw_go, w_go, done;
		begin
			@(posedge core_clk_i);
			s_axi_awaddr_i <= a;
			s_axi_wdata_i <= d;
			s_axi_wstrb_i <= s;
			s_axi_awvalid_i <= 1'b1;
			s_axi_wvalid_i <= 1'b1;
			done = 1'b0;
			while (!done) begin
				@(negedge core_clk_i);
				aw_go = s_axi_awready_o;
				w_go = s_axi_wready_o;
				done = s_axi_bvalid_o;
				r = s_axi_bresp_o;
				@(posedge core_clk_i);
				if (aw_go)
					s_axi_awvalid_i <= 1'b0;
				if (w_go)
					s_axi_wvalid_i <= 1'b0;
			end
		end
	endtask
	task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
		reg ar_go, done;
		begin
			@(posedge core_clk_i);
			s_axi_araddr_i <= a;
			s_axi_arvalid_i <= 1'b1;
			done = 1'b0;
			while (!done) begin
				@(negedge core_clk_i);
				ar_go = s_axi_arready_o;
				done = s_axi_rvalid_o;
				d = s_axi_rdata_o;
				r = s_axi_rresp_o;
				@(posedge core_clk_i);
				if (ar_go)
					s_axi_arvalid_i <= 1'b0;
			end
		end
	endtask
	// expected pad drive; returns the peripheral-owned pads
	function [19:0] pad_model(input [18:0] s, output [19:0] o,
		output [19:0] e, output [19:0] m);
		begin
			o = gpio_out_i;
			e = gpio_oe_n_i;
			m = 20'hfffff;
			pad_model = {~s[3], {6{~s[4]}}, {3{~s[5]}}, s[6], {6{s[7]}},
				s[8], s[9], s[10]};
			if (s[10])
				{o[0], e[0]} = {external_clock_out_1_i, 1'b0};
			if (s[9])
				{o[1], e[1]} = {s[16] ? osc_32k_clock_i :
					external_clock_out_0_i, 1'b0};
			if (s[8])
				{o[2], e[2]} = {infrared_mode_select_out_i, 1'b0};
			if (s[7])
				{o[4:3], e[8:3], m[8:5]} = {uart3_request_to_send_n_i,
					uart3_terminal_ready_n_i, 6'h3c, 4'h0};
			if (s[6])
				{e[9], m[9]} = 2'b10;
			if (!s[5]) begin
				{o[12:10], e[12:10]} = {serial_audio_data_bidir_i,
					serial_audio_bit_clock_i, serial_audio_word_select_i,
					serial_audio_data_bidir_oe_n_i,
					serial_audio_bit_clock_oe_n_i,
					serial_audio_word_select_oe_n_i};
				m[12:10] = ~e[12:10];
			end
			if (!s[4])
				{o[18:13], e[18:13]} = {eth0_mgmt_clock_i,
					eth0_tx_enable_i, eth0_tx_data_i, 6'h00};
			if (!s[3])
				{o[19], e[19]} = {uart0_tx_data_i, 1'b0};
		end
	endfunction
	task check_pads;
		reg [19:0] o, e, m, own, pin;
		begin
			repeat (4) @(posedge core_clk_i);
			@(negedge core_clk_i);
			own = pad_model(sel_exp, o, e, m);
			pin = (o & ~e) | (board & e);
			cmp_word({13'h0, pin_function_o}, {13'h0, sel_exp});
			cmp_pads(pad_out_o, o, m);
			cmp_pads(pad_oe_n_o, e, 20'hfffff);
			cmp_pads(gpio_in_o, pin & ~own, 20'hfffff);
			cmp_pads({serial_audio_data_bidir_o, serial_audio_bit_clock_o,
				serial_audio_word_select_o, serial_audio_data_in_o,
				uart3_clear_to_send_n_o, uart3_set_ready_n_o,
				uart3_carrier_detect_n_o, uart3_ring_indicator_n_o},
				{~sel_exp[5] ? pin[12:10] : 3'h0, sel_exp[6] & pin[9],
				sel_exp[7] ? pin[8:5] : 4'hf}, 20'h000ff);
		end
	endtask
	// modem irq mask and audio receive stop have no port here
	task drive_random;
		reg [31:0] a, b, c;
		begin
			a = $urandom;
			b = $urandom;
			c = $urandom;
			@(posedge core_clk_i);
			gpio_out_i <= a[19:0];
			// gpio8 is forced to drive while bits 6 and 5 are both zero and c[0] is set
			gpio_oe_n_i <= b[19:0] & ~{10'h0,
				~sel_exp[6] & ~sel_exp[5] & c[0], 9'h0};
			board <= {a[31:20], b[31:24]};
			{serial_audio_bit_clock_oe_n_i, serial_audio_word_select_oe_n_i,
				serial_audio_data_bidir_i, serial_audio_bit_clock_i,
				serial_audio_word_select_i, infrared_mode_select_out_i,
				uart3_terminal_ready_n_i, uart3_request_to_send_n_i,
				eth0_tx_data_i, eth0_tx_enable_i, eth0_mgmt_clock_i,
				uart0_tx_data_i, serial_audio_data_bidir_oe_n_i} <= c[15:0];
		end
	endtask

	initial begin
		rd = $urandom(32'hf01d);
		repeat (20) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		// reset state, every pad with general-purpose logic
		sel_exp = `PFSEL_FUNC_RESET;
		axi_read(`PFSEL_OFF_FUNC, rd, rs);
		cmp_word(rd, {13'h0, sel_exp});
		check_pads;
		axi_read(`PFSEL_OFF_PADS, rd, rs);
		cmp_word(rd, {12'h0, board});
		// refused write and unmapped read leave the select word alone
		axi_write(`PFSEL_OFF_PADS, 32'hffffffff, 4'hf, rs);
		cmp_word(rs, `PFSEL_RESP_SLVERR);
		axi_read(8'h08, rd, rs);
		cmp_word(rd, 32'h0);
		cmp_word(rs, `PFSEL_RESP_SLVERR);
		// byte strobes, reserved bits stay zero
		axi_write(`PFSEL_OFF_FUNC, 32'h0, 4'h2, rs);
		axi_write(`PFSEL_OFF_FUNC, 32'hffffffff, 4'h4, rs);
		axi_read(`PFSEL_OFF_FUNC, rd, rs);
		cmp_word(rd, 32'h7003d);
		// corner select words first, then random ones
		for (k = 0; k < 40; k = k + 1) begin
			v = $urandom;
			sel_exp = k == 0 ? 19'h0 : k == 1 ? 19'h7ffff :
				k == 2 ? 19'h10200 : k == 3 ? 19'h00200 : v[18:0];
			axi_write(`PFSEL_OFF_FUNC, {v[31:19], sel_exp}, 4'hf, rs);
			cmp_word(rs, `PFSEL_RESP_OKAY);
			axi_read(`PFSEL_OFF_FUNC, rd, rs);
			cmp_word(rd, {13'h0, sel_exp});
			drive_random;
			check_pads;
		end
		print_verdict;
	end
endmodule // tb_pin_function_select_low_fields
